// *** hw/msil_pkg.sv ***
// Purpose: shared constants for the measurement status and interrupt logic
// Assumes: 32-bit APB register bus, one clock domain
// Notes: register offsets are byte addresses
package msil_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned NUM_COND = 8;
   localparam int unsigned FILL_W = 17;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATE = 8'h04;
   localparam logic [7:0] OFS_OPERATION_STATUS_GROUP_EVENT = 8'h08;
   localparam logic [7:0] OFS_OPERATION_STATUS_GROUP_ENABLE = 8'h0C;
   localparam logic [7:0] OFS_QUESTIONABLE_DATA_GROUP_EVENT = 8'h10;
   localparam logic [7:0] OFS_QUESTIONABLE_DATA_GROUP_ENABLE = 8'h14;
   localparam logic [7:0] OFS_SETUP = 8'h18;
   localparam logic [7:0] OFS_TRIG_COUNT = 8'h1C;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
   localparam logic [7:0] OFS_OPERATION_STATUS_GROUP_COND = 8'h28;

   // control register bits (commands act on a written one; CTRL_GLOBAL_EN is a level set by every CTRL write that does not carry CTRL_PRESET)
   localparam int unsigned CTRL_INIT = 0;
   localparam int unsigned CTRL_ABORT = 1;
   localparam int unsigned CTRL_PRESET = 2;
   localparam int unsigned CTRL_OPC = 3;
   localparam int unsigned CTRL_RESET = 4;
   localparam int unsigned CTRL_GLOBAL_EN = 5;

   // condition vector positions
   localparam int unsigned C_TRIG_FAST = 0;
   localparam int unsigned C_OVERFLOW = 1;
   localparam int unsigned C_OVERVOLT = 2;
   localparam int unsigned C_SCAN_DONE = 3;
   localparam int unsigned C_PLUGON_TRIG = 4;
   localparam int unsigned C_HALF_FULL = 5;
   localparam int unsigned C_MEAS_DONE = 6;
   localparam int unsigned C_ALG_IRQ = 7;

   // operation group bit positions
   localparam int unsigned OPERATION_STATUS_GROUP_SCAN_DONE = 8;
   localparam int unsigned OPERATION_STATUS_GROUP_MEASURING = 4;
   localparam int unsigned OPERATION_STATUS_GROUP_PLUGON_TRIG = 9;
   localparam int unsigned OPERATION_STATUS_GROUP_HALF_FULL = 10;
   localparam int unsigned OPERATION_STATUS_GROUP_ALG_IRQ = 11;
   localparam int unsigned OPERATION_STATUS_GROUP_MEAS_DONE = 12;
   // questionable group bit positions
   localparam int unsigned QUESTIONABLE_DATA_GROUP_OVERVOLT = 9;
   localparam int unsigned QUESTIONABLE_DATA_GROUP_OVERFLOW = 10;
   localparam int unsigned QUESTIONABLE_DATA_GROUP_TRIG_FAST = 11;

   localparam logic [FILL_W-1:0] HALF_FULL_LEVEL = 17'h08000;
   localparam logic [15:0] GRP_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_ARM, ST_MEASURE} run_state_t;
endpackage : msil_pkg

// *** hw/msil_sticky.sv ***
// Purpose: bank of sticky event bits, set wins over clear
// Assumes: synchronous set pulses
// Notes: used for the operation and questionable event registers
`timescale 1ns/1ns
module msil_sticky
#(
   parameter int unsigned W = 16
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // control
   input wire logic [W-1:0] i_set,
   input wire logic [W-1:0] i_clr,
   // state
   output logic [W-1:0] o_q
);
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_q <= '0;
      end
      else
      begin
         // a set arriving with a clear is kept
         o_q <= (o_q & ~i_clr) | i_set;
      end
   end
endmodule : msil_sticky

// *** hw/msil_trigger_seq.sv ***
// Purpose: run state sequencer of the measurement engine
// Assumes: trigger and arm inputs are one-cycle pulses
// Notes: runs on its own once initiated
`timescale 1ns/1ns
module msil_trigger_seq
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // commands
   input wire logic i_init,
   input wire logic i_abort,
   input wire logic [15:0] i_trig_count,
   // engine events
   input wire logic i_arm,
   input wire logic i_trigger,
   input wire logic i_meas_end,
   // status
   output msil_pkg::run_state_t o_state,
   output logic o_trig_fast,
   output logic o_meas_done,
   output logic o_count_reached
);
   import msil_pkg::*;
   logic [15:0] trig_seen;

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_state <= ST_IDLE;
         trig_seen <= 16'h0000;
         o_trig_fast <= 1'b0;
         o_meas_done <= 1'b0;
         o_count_reached <= 1'b0;
      end
      else
      begin
         o_trig_fast <= 1'b0;
         o_meas_done <= 1'b0;
         o_count_reached <= 1'b0;
         case (o_state)
            ST_IDLE:
            begin
               if (i_init)
               begin
                  o_state <= ST_WAIT_ARM;
                  trig_seen <= 16'h0000;
               end
            end
            ST_WAIT_ARM:
            begin
               if (i_abort)
                  o_state <= ST_IDLE;
               else if (i_arm)
               begin
                  o_state <= ST_MEASURE;
                  o_meas_done <= 1'b1;
               end
               else if (i_trigger)
                  o_trig_fast <= 1'b1;
            end
            ST_MEASURE:
            begin
               // a trigger landing with the end of a measurement must not swallow that end
               if (i_trigger && i_meas_end)
                  o_trig_fast <= 1'b1;
               if (i_abort)
                  o_state <= ST_IDLE;
               else if (i_meas_end)
               begin
                  trig_seen <= trig_seen + 16'h0001;
                  if (trig_seen + 16'h0001 >= i_trig_count)
                  begin
                     o_state <= ST_IDLE;
                     o_count_reached <= 1'b1;
                  end
                  else
                     o_state <= ST_WAIT_ARM;
               end
            end
            default:
               o_state <= ST_IDLE;
         endcase
      end
   end
endmodule : msil_trigger_seq

// *** hw/measurement_status_interrupt_logic.sv ***
// Purpose: status groups and interrupt requests of a scanning measurement engine
// Assumes: APB slave, single 100 MHz clock, engine events as one-cycle pulses
// Notes: event registers clear on read; irq status is write-one-to-clear
`timescale 1ns/1ns
module measurement_status_interrupt_logic
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [msil_pkg::ADDR_W-1:0] i_paddr,
   input wire logic [msil_pkg::DATA_W-1:0] i_pwdata,
   output logic [msil_pkg::DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // measurement engine events
   input wire logic i_arm,
   input wire logic i_trigger,
   input wire logic i_meas_end,
   input wire logic i_scan_list_done,
   input wire logic i_plugon_trigger,
   input wire logic i_alg_interrupt,
   input wire logic i_buf_write,
   input wire logic i_buf_read,
   input wire logic i_overvoltage,
   input wire logic i_protect_intact,
   // engine control
   output logic o_relays_open,
   output logic o_measuring,
   output logic [msil_pkg::DATA_W-1:0] o_setup,
   // interrupt
   output logic o_irq
);
   import msil_pkg::*;

   logic rst_meta;
   logic rstn;
   logic wr_en;
   logic rd_en;
   logic setup_en;
   logic [15:0] trig_count;
   logic global_en;
   logic opc_pending;
   logic [15:0] operation_status_group_enable;
   logic [15:0] questionable_data_group_enable;
   logic [15:0] operation_status_group_event;
   logic [15:0] questionable_data_group_event;
   logic [15:0] operation_status_group_set;
   logic [15:0] questionable_data_group_set;
   logic [15:0] operation_status_group_clr;
   logic [15:0] questionable_data_group_clr;
   logic [NUM_COND-1:0] cond;
   logic [NUM_COND-1:0] irq_status;
   logic [NUM_COND-1:0] irq_mask;
   logic [NUM_COND-1:0] cond_en;
   logic [FILL_W-1:0] fill;
   logic buf_full;
   logic half_prev;
   logic overflow;
   logic trig_fast;
   logic meas_done;
   logic count_reached;
   logic cmd_init;
   logic cmd_abort;
   logic cmd_preset;
   logic cmd_opc;
   logic cmd_reset;
   run_state_t run_state;
   logic [DATA_W-1:0] next_prdata;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // reset release synchroniser
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         rst_meta <= 1'b0;
         rstn <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rstn <= rst_meta;
      end
   end

   // apb answers in the access phase with no wait states
   assign wr_en = i_psel && i_penable && i_pwrite;
   assign rd_en = i_psel && i_penable && !i_pwrite;
   assign cmd_init = wr_en && hit(i_paddr, OFS_CTRL) && i_pwdata[CTRL_INIT];
   assign cmd_abort = wr_en && hit(i_paddr, OFS_CTRL) && i_pwdata[CTRL_ABORT];
   assign cmd_preset = wr_en && hit(i_paddr, OFS_CTRL) && i_pwdata[CTRL_PRESET];
   assign cmd_opc = wr_en && hit(i_paddr, OFS_CTRL) && i_pwdata[CTRL_OPC];
   assign cmd_reset = wr_en && hit(i_paddr, OFS_CTRL) && i_pwdata[CTRL_RESET];
   assign setup_en = (run_state == ST_IDLE);

   msil_trigger_seq u_seq
   (
      .i_clk(i_clk_sys),
      .i_rstn(rstn),
      .i_init(cmd_init),
      .i_abort(cmd_abort),
      .i_trig_count(trig_count),
      .i_arm(i_arm),
      .i_trigger(i_trigger),
      .i_meas_end(i_meas_end),
      .o_state(run_state),
      .o_trig_fast(trig_fast),
      .o_meas_done(meas_done),
      .o_count_reached(count_reached)
   );

   // buffer occupancy tracking
   assign buf_full = fill[FILL_W-1];
   always_ff @(posedge i_clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         fill <= '0;
         half_prev <= 1'b0;
      end
      else
      begin
         half_prev <= (fill >= HALF_FULL_LEVEL);
         if (cmd_reset)
            fill <= '0;
         else if (i_buf_write && !buf_full && !(i_buf_read && fill != '0))
            fill <= fill + 1'b1;
         else if (i_buf_read && fill != '0 && !(i_buf_write && !buf_full))
            fill <= fill - 1'b1;
      end
   end
   assign overflow = i_buf_write && buf_full && !i_buf_read;

   // condition pulses; half-full fires on the rising crossing
   always_comb
   begin
      cond = '0;
      cond[C_TRIG_FAST] = trig_fast;
      cond[C_OVERFLOW] = overflow;
      cond[C_OVERVOLT] = i_overvoltage && i_protect_intact;
      cond[C_SCAN_DONE] = i_scan_list_done;
      cond[C_PLUGON_TRIG] = i_plugon_trigger;
      cond[C_HALF_FULL] = (fill >= HALF_FULL_LEVEL) && !half_prev;
      cond[C_MEAS_DONE] = meas_done;
      cond[C_ALG_IRQ] = i_alg_interrupt;
   end

   always_comb
   begin
      operation_status_group_set = '0;
      questionable_data_group_set = '0;
      operation_status_group_set[OPERATION_STATUS_GROUP_SCAN_DONE] = cond[C_SCAN_DONE];
      operation_status_group_set[OPERATION_STATUS_GROUP_PLUGON_TRIG] = cond[C_PLUGON_TRIG];
      operation_status_group_set[OPERATION_STATUS_GROUP_HALF_FULL] = cond[C_HALF_FULL];
      operation_status_group_set[OPERATION_STATUS_GROUP_MEAS_DONE] = cond[C_MEAS_DONE];
      operation_status_group_set[OPERATION_STATUS_GROUP_ALG_IRQ] = cond[C_ALG_IRQ];
      questionable_data_group_set[QUESTIONABLE_DATA_GROUP_OVERVOLT] = cond[C_OVERVOLT];
      questionable_data_group_set[QUESTIONABLE_DATA_GROUP_OVERFLOW] = cond[C_OVERFLOW];
      questionable_data_group_set[QUESTIONABLE_DATA_GROUP_TRIG_FAST] = cond[C_TRIG_FAST];
      // clear only the bits the reader was shown, so an event after the snapshot survives
      operation_status_group_clr = (rd_en && hit(i_paddr, OFS_OPERATION_STATUS_GROUP_EVENT)) ? o_prdata[15:0] : GRP_RESET;
      questionable_data_group_clr = (rd_en && hit(i_paddr, OFS_QUESTIONABLE_DATA_GROUP_EVENT)) ? o_prdata[15:0] : GRP_RESET;
   end

   msil_sticky #(.W(16)) u_operation_status_group_event
   (
      .i_clk(i_clk_sys),
      .i_rstn(rstn),
      .i_set(operation_status_group_set),
      .i_clr(operation_status_group_clr),
      .o_q(operation_status_group_event)
   );

   msil_sticky #(.W(16)) u_questionable_data_group_event
   (
      .i_clk(i_clk_sys),
      .i_rstn(rstn),
      .i_set(questionable_data_group_set),
      .i_clr(questionable_data_group_clr),
      .o_q(questionable_data_group_event)
   );

   // per-condition enable taken from the group enable bits; meas done is also enabled by opc_pending
   always_comb
   begin
      cond_en = '0;
      cond_en[C_TRIG_FAST] = questionable_data_group_enable[QUESTIONABLE_DATA_GROUP_TRIG_FAST];
      cond_en[C_OVERFLOW] = questionable_data_group_enable[QUESTIONABLE_DATA_GROUP_OVERFLOW];
      cond_en[C_OVERVOLT] = questionable_data_group_enable[QUESTIONABLE_DATA_GROUP_OVERVOLT];
      cond_en[C_SCAN_DONE] = operation_status_group_enable[OPERATION_STATUS_GROUP_SCAN_DONE];
      cond_en[C_PLUGON_TRIG] = operation_status_group_enable[OPERATION_STATUS_GROUP_PLUGON_TRIG];
      cond_en[C_HALF_FULL] = operation_status_group_enable[OPERATION_STATUS_GROUP_HALF_FULL];
      cond_en[C_MEAS_DONE] = operation_status_group_enable[OPERATION_STATUS_GROUP_MEAS_DONE] || opc_pending;
      cond_en[C_ALG_IRQ] = operation_status_group_enable[OPERATION_STATUS_GROUP_ALG_IRQ];
   end

   // enables, mask, setup and global switch
   always_ff @(posedge i_clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         operation_status_group_enable <= GRP_RESET;
         questionable_data_group_enable <= GRP_RESET;
         irq_mask <= '0;
         global_en <= 1'b0;
         o_setup <= ZERO_WORD;
         trig_count <= 16'h0001;
      end
      else if (cmd_preset)
      begin
         operation_status_group_enable <= GRP_RESET;
         questionable_data_group_enable <= GRP_RESET;
      end
      else if (wr_en)
      begin
         if (hit(i_paddr, OFS_OPERATION_STATUS_GROUP_ENABLE))
            operation_status_group_enable <= i_pwdata[15:0];
         if (hit(i_paddr, OFS_QUESTIONABLE_DATA_GROUP_ENABLE))
            questionable_data_group_enable <= i_pwdata[15:0];
         if (hit(i_paddr, OFS_IRQ_MASK))
            irq_mask <= i_pwdata[NUM_COND-1:0];
         if (hit(i_paddr, OFS_CTRL))
            global_en <= i_pwdata[CTRL_GLOBAL_EN];
         if (hit(i_paddr, OFS_SETUP) && setup_en)
            o_setup <= i_pwdata;
         if (hit(i_paddr, OFS_TRIG_COUNT) && setup_en)
            trig_count <= i_pwdata[15:0];
      end
   end

   // one-shot completion request; dropped once reported
   always_ff @(posedge i_clk_sys or negedge rstn)
   begin
      if (!rstn)
         opc_pending <= 1'b0;
      else if (cmd_opc)
         opc_pending <= 1'b1;
      else if (cmd_preset || meas_done)
         opc_pending <= 1'b0;
   end

   // sticky interrupt status, write one to clear; set wins
   always_ff @(posedge i_clk_sys or negedge rstn)
   begin
      if (!rstn)
         irq_status <= '0;
      else if (wr_en && hit(i_paddr, OFS_IRQ_STATUS))
         irq_status <= (irq_status & ~i_pwdata[NUM_COND-1:0]) | (cond & cond_en);
      else
         irq_status <= irq_status | (cond & cond_en);
   end

   always_ff @(posedge i_clk_sys or negedge rstn)
   begin
      if (!rstn)
         o_irq <= 1'b0;
      else
         o_irq <= global_en && |(irq_status & irq_mask);
   end

   // overvoltage latch held until a full reset command
   always_ff @(posedge i_clk_sys or negedge rstn)
   begin
      if (!rstn)
         o_relays_open <= 1'b0;
      else if (cond[C_OVERVOLT])
         o_relays_open <= 1'b1;
      else if (cmd_reset)
         o_relays_open <= 1'b0;
   end

   // measuring bit of the operation group
   always_ff @(posedge i_clk_sys or negedge rstn)
   begin
      if (!rstn)
         o_measuring <= 1'b0;
      else if (cmd_init)
         o_measuring <= 1'b1;
      else if (meas_done || cmd_abort || count_reached)
         o_measuring <= 1'b0;
   end

   // reads stay served in every run state
   always_comb
   begin
      next_prdata = ZERO_WORD;
      case (i_paddr)
         OFS_CTRL: next_prdata[CTRL_GLOBAL_EN] = global_en;
         OFS_STATE: next_prdata = {28'h0000000, fill == '0, o_relays_open, run_state};
         OFS_OPERATION_STATUS_GROUP_EVENT: next_prdata[15:0] = operation_status_group_event;
         OFS_OPERATION_STATUS_GROUP_ENABLE: next_prdata[15:0] = operation_status_group_enable;
         OFS_QUESTIONABLE_DATA_GROUP_EVENT: next_prdata[15:0] = questionable_data_group_event;
         OFS_QUESTIONABLE_DATA_GROUP_ENABLE: next_prdata[15:0] = questionable_data_group_enable;
         OFS_SETUP: next_prdata = o_setup;
         OFS_TRIG_COUNT: next_prdata[15:0] = trig_count;
         OFS_IRQ_STATUS: next_prdata[NUM_COND-1:0] = irq_status;
         OFS_IRQ_MASK: next_prdata[NUM_COND-1:0] = irq_mask;
         OFS_OPERATION_STATUS_GROUP_COND: next_prdata[OPERATION_STATUS_GROUP_MEASURING] = o_measuring;
         default: next_prdata = ZERO_WORD;
      endcase
   end

   // prdata registered in setup phase, so pready may rise in access phase
   always_ff @(posedge i_clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         o_prdata <= ZERO_WORD;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_prdata <= next_prdata;
         o_pready <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && (i_paddr[1:0] != 2'b00 || i_paddr > OFS_OPERATION_STATUS_GROUP_COND);
      end
   end
endmodule : measurement_status_interrupt_logic

// *** tb/msil_props.sv ***
// Purpose: port-level checks of the status and interrupt block
// Assumes: APB master holds each request until pready
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ns
module msil_props
import msil_pkg::*;
(
   // clock, reset, bus
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [msil_pkg::ADDR_W-1:0] i_paddr,
   input wire logic [msil_pkg::DATA_W-1:0] i_pwdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // engine side
   input wire logic i_arm,
   input wire logic i_overvoltage,
   input wire logic i_protect_intact,
   input wire logic o_relays_open,
   input wire logic o_measuring,
   input wire logic [msil_pkg::DATA_W-1:0] o_setup,
   input wire logic o_irq
);
   wire wr_done = i_psel & i_penable & i_pwrite & o_pready;
   wire ctrl_wr = wr_done & (i_paddr == OFS_CTRL);
   wire rst_wr = ctrl_wr & i_pwdata[CTRL_RESET];
   wire setup_wr = wr_done & (i_paddr == OFS_SETUP);
   wire mask_off = wr_done & (i_paddr == OFS_IRQ_MASK) & (i_pwdata[7:0] == 8'h00);
   wire ov_hit = i_overvoltage & i_protect_intact;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   a_pready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
      else $error("pready missing in access phase");
   a_pready_in_access: assert property (o_pready |-> i_psel && i_penable)
      else $error("pready outside access phase");
   a_slverr_past_map: assert property (o_pready && i_paddr > OFS_OPERATION_STATUS_GROUP_COND |-> o_pslverr)
      else $error("no error for unmapped address");
   a_irq_mask_off: assert property (mask_off |-> ##2 !o_irq)
      else $error("irq high with mask cleared");
   a_irq_global_off: assert property (ctrl_wr && !i_pwdata[CTRL_GLOBAL_EN] |-> ##2 !o_irq)
      else $error("irq high with global enable off");
   a_relays_open_ov: assert property (ov_hit |-> ##[1:2] o_relays_open)
      else $error("relays not opened on overvoltage");
   a_relays_hold_open: assert property (o_relays_open |=> o_relays_open || $past(rst_wr) || $past(rst_wr, 2))
      else $error("relays closed without full reset");
   a_relays_need_cause: assert property ($rose(o_relays_open) |-> $past(ov_hit) || $past(ov_hit, 2))
      else $error("relays opened without overvoltage");
   a_setup_change_cause: assert property (!$stable(o_setup) |-> $past(setup_wr) || $past(setup_wr, 2))
      else $error("setup changed without a write");
   a_measuring_clears: assert property (i_arm |-> ##[1:2] !o_measuring)
      else $error("measuring not cleared on arm exit");
   c_irq: cover property ($rose(o_irq));
   c_relays: cover property ($rose(o_relays_open));
   c_slverr: cover property (o_pready && o_pslverr);
endmodule : msil_props
bind measurement_status_interrupt_logic msil_props u_props (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_arm(i_arm), .i_overvoltage(i_overvoltage),
   .i_protect_intact(i_protect_intact), .o_relays_open(o_relays_open), .o_measuring(o_measuring),
   .o_setup(o_setup), .o_irq(o_irq));

// *** tb/msil_host_model.sv ***
// Purpose: backplane host that reaches the block over APB
// Assumes: slave answers with pready; no fixed wait assumed
// Notes: address and data lines show the inverse while idle
`timescale 1ns/1ns
module msil_host_model
(
   // clock
   input wire logic i_clk,
   // answer
   input wire logic [31:0] i_prdata,
   input wire logic i_pready,
   input wire logic i_pslverr,
   // request
   output logic o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output logic [7:0] o_paddr,
   output logic [31:0] o_pwdata
);
   initial
   begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 8'h00;
      o_pwdata = 32'h00000000;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      @(posedge i_clk);
      o_psel <= 1'b1;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_clk);
      o_penable <= 1'b1;
      // no wait limit here: only the bench watchdog ends a stuck transfer
      do @(posedge i_clk); while (i_pready !== 1'b1);
      // status copy is refreshed on every access
      q = i_prdata;
      e = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      o_paddr <= ~a;
      o_pwdata <= ~d;
   endtask : xfer
endmodule : msil_host_model

// *** tb/measurement_status_interrupt_logic_tb_top.sv ***
// Purpose: directed register-level tests of the status and interrupt block
// Assumes: host model issues all bus cycles
// Notes: engine events are single-cycle pulses
`timescale 1ns/1ns
module measurement_status_interrupt_logic_tb_top;
   import msil_pkg::*;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq, relays, measuring, e;
   logic arm, trig, mend, scan, plug, alg, bw, br, ov, prot;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, setup, q;
   int fail_count, checked;
   int ib[5] = '{3, 4, 7, 6, 2};
   int gb[5] = '{8, 9, 11, 12, 9};
   measurement_status_interrupt_logic uut (.i_clk_sys(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_arm(arm), .i_trigger(trig), .i_meas_end(mend), .i_scan_list_done(scan),
      .i_plugon_trigger(plug), .i_alg_interrupt(alg), .i_buf_write(bw), .i_buf_read(br), .i_overvoltage(ov),
      .i_protect_intact(prot), .o_relays_open(relays), .o_measuring(measuring), .o_setup(setup), .o_irq(irq));
   msil_host_model host (.i_clk(clk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr), .o_psel(psel),
      .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h00000000, q, e);
      chk($sformatf("reg %h", a), q, exp);
   endtask : rd
   // 0 scan, 1 plug-on, 2 algorithm, 3 arm exit, 4 trigger, 5 overvoltage, 6 measurement end
   task automatic pulse(input int k);
      @(posedge clk);
      case (k)
         0: scan <= 1'b1;
         1: plug <= 1'b1;
         2: alg <= 1'b1;
         3: arm <= 1'b1;
         4: trig <= 1'b1;
         6: mend <= 1'b1;
         default: ov <= 1'b1;
      endcase
      @(posedge clk);
      {scan, plug, alg, arm, trig, ov, mend} <= 7'h00;
      repeat (4) @(posedge clk);
   endtask : pulse
   task automatic burst(input int n);
      @(posedge clk);
      bw <= 1'b1;
      repeat (n) @(posedge clk);
      bw <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : burst
   task results();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #900000;
      fail_count++;
      results();
   end
   initial
   begin
      {rstn, arm, trig, mend, scan, plug, alg, bw, br, ov, prot} = 11'h000;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(OFS_TRIG_COUNT, 32'h00000001);
      rd(OFS_IRQ_MASK, 32'h00000000);
      rd(OFS_OPERATION_STATUS_GROUP_ENABLE, 32'h00000000);
      rd(8'h2C, 32'h00000000);
      chk("pslverr", e, 1'b1);
      $display("reset test done");
      wr(OFS_IRQ_MASK, 32'h00000000);
      wr(OFS_CTRL, 32'h00000020);
      pulse(0);
      rd(OFS_IRQ_STATUS, 32'h00000000);
      rd(OFS_OPERATION_STATUS_GROUP_EVENT, 32'h00000100);
      wr(OFS_SETUP, 32'h00000055);
      wr(OFS_CTRL, 32'h00000021);
      rd(OFS_STATE, 32'h00000009);
      wr(OFS_SETUP, 32'h000000AA);
      rd(OFS_SETUP, 32'h00000055);
      wr(OFS_CTRL, 32'h00000022);
      rd(OFS_STATE, 32'h00000008);
      wr(OFS_SETUP, 32'h000000AA);
      @(posedge clk);
      chk("setup", setup, 32'h000000AA);
      $display("setup lock test done");
      wr(OFS_OPERATION_STATUS_GROUP_ENABLE, 32'h00001F00);
      wr(OFS_QUESTIONABLE_DATA_GROUP_ENABLE, 32'h00000E00);
      wr(OFS_IRQ_MASK, 32'h000000FF);
      wr(OFS_CTRL, 32'h00000021);
      pulse(4);
      rd(OFS_QUESTIONABLE_DATA_GROUP_EVENT, 32'h00000800);
      rd(OFS_IRQ_STATUS, 32'h00000001);
      wr(OFS_CTRL, 32'h00000022);
      wr(OFS_IRQ_STATUS, 32'h000000FF);
      burst(32767);
      rd(OFS_IRQ_STATUS, 32'h00000000);
      burst(1);
      rd(OFS_IRQ_STATUS, 32'h00000020);
      rd(OFS_OPERATION_STATUS_GROUP_EVENT, 32'h00000400);
      wr(OFS_IRQ_STATUS, 32'h000000FF);
      burst(32768);
      rd(OFS_IRQ_STATUS, 32'h00000000);
      burst(1);
      rd(OFS_IRQ_STATUS, 32'h00000002);
      rd(OFS_QUESTIONABLE_DATA_GROUP_EVENT, 32'h00000400);
      wr(OFS_IRQ_STATUS, 32'h000000FF);
      $display("buffer test done");
      prot <= 1'b1;
      wr(OFS_CTRL, 32'h00000021);
      @(posedge clk);
      chk("measuring", measuring, 1'b1);
      for (int i = 0; i < 5; i++)
      begin
         pulse(i == 4 ? 5 : i);
         chk("irq", irq, 1'b1);
         rd(OFS_IRQ_STATUS, 32'h1 << ib[i]);
         rd(i == 4 ? OFS_QUESTIONABLE_DATA_GROUP_EVENT : OFS_OPERATION_STATUS_GROUP_EVENT, 32'h1 << gb[i]);
         rd(i == 4 ? OFS_QUESTIONABLE_DATA_GROUP_EVENT : OFS_OPERATION_STATUS_GROUP_EVENT, 32'h00000000);
         wr(OFS_IRQ_STATUS, 32'h000000FF);
         repeat (3) @(posedge clk);
         chk("irq", irq, 1'b0);
      end
      chk("relays", relays, 1'b1);
      chk("measuring", measuring, 1'b0);
      $display("event test done");
      wr(OFS_CTRL, 32'h00000002);
      pulse(1);
      chk("irq", irq, 1'b0);
      wr(OFS_CTRL, 32'h00000020);
      repeat (3) @(posedge clk);
      chk("irq", irq, 1'b1);
      wr(OFS_IRQ_STATUS, 32'h000000FF);
      wr(OFS_CTRL, 32'h00000024);
      rd(OFS_OPERATION_STATUS_GROUP_ENABLE, 32'h00000000);
      rd(OFS_QUESTIONABLE_DATA_GROUP_ENABLE, 32'h00000000);
      pulse(0);
      chk("irq", irq, 1'b0);
      wr(OFS_IRQ_MASK, 32'h000000FF);
      wr(OFS_CTRL, 32'h00000029);
      pulse(3);
      chk("irq", irq, 1'b1);
      rd(OFS_IRQ_STATUS, 32'h00000040);
      wr(OFS_IRQ_STATUS, 32'h000000FF);
      wr(OFS_CTRL, 32'h00000022);
      wr(OFS_CTRL, 32'h00000021);
      pulse(3);
      chk("irq", irq, 1'b0);
      rd(OFS_IRQ_STATUS, 32'h00000000);
      pulse(6);
      rd(OFS_STATE, 32'h00000004);
      $display("enable test done");
      chk("relays", relays, 1'b1);
      wr(OFS_CTRL, 32'h00000030);
      repeat (4) @(posedge clk);
      chk("relays", relays, 1'b0);
      $display("relay test done");
      results();
   end
endmodule : measurement_status_interrupt_logic_tb_top
